// >>> rtl/rrsf_regs.vh
// Register offsets, field positions and reset values of the receive status flags
`ifndef RRSF_REGS_VH
`define RRSF_REGS_VH
`define RRSF_ADDR_BUFFER     8'h00
`define RRSF_ADDR_CTRL       8'h05
`define RRSF_ADDR_FLAGS      8'h07
`define RRSF_ADDR_PKT_STATUS 8'h08
`define RRSF_ADDR_COUNT      8'h09
`define RRSF_ADDR_LENGTH     8'h0A
`define RRSF_CTRL_RESET      8'h07
`define RRSF_FLAGS_RESET     8'h00
`define RRSF_STATUS_RESET    8'h08
`define RRSF_ZERO8           8'h00
`define RRSF_ONE8            8'h01
`define RRSF_ONE5            5'h01
`define RRSF_HALF_LEVEL      5'h08
`define RRSF_DEPTH           5'h10
`define RRSF_DEPTH_LAST      5'h0F
`define RRSF_PTR_ONE         4'h1
`define RRSF_MODE_GFSK       2'h0
`define RRSF_MODE_INVALID    2'h3
`define RRSF_BIT_START       7
`define RRSF_BIT_FULL        5
`define RRSF_BIT_HALF        4
`define RRSF_BIT_NOT_EMPTY   3
`define RRSF_BIT_BUF_ERR     2
`define RRSF_BIT_COMPLETE    1
`define RRSF_BIT_ERROR       0
`endif

// >>> rtl/rrsf_top.v
// Receive buffer, event flags, packet status, byte count and length registers
`timescale 1ns/10ps
`include "rrsf_regs.vh"

// Notes on behaviour
// - Half-full flag when eight or more bytes
// - Not-empty flag while any byte buffered
// - Buffer error on underrun or overrun; start clears
// - Complete after ACK sent in transaction mode
// - Reading event flags clears complete and error
// - Error on CRC, early end, type, drop
// - Status bit7 set for ACK packet
// - Status bit6 flags unexpected packet type
// - Status bit5 early end, cleared next start
// - Bit4 zero seed, bit3 bad CRC
// - Bit2 code length of last good packet
// - Bits1:0 data mode of last good packet
// - Counter counts payload bytes, equals length
// - Counter cleared whenever length register loads
// - Length loaded from field; bad field loads zero outside GFSK
// - Receive start self-clears on completion or error
// - Interrupt when any flag and enable set
module rrsf_top (
	input  wire       clk,
	input  wire       rst_n,
	input  wire       reg_rd,
	input  wire       reg_wr,
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	output reg  [7:0] reg_rdata,
	output reg        irq,
	output reg        rx_go,
	input  wire       ack_enable,
	input  wire       packet_start_pattern,
	input  wire       rx_byte_valid,
	input  wire [7:0] rx_byte,
	input  wire       length_valid,
	input  wire [7:0] length_value,
	input  wire       length_bad,
	input  wire       packet_done,
	input  wire       ack_sent,
	input  wire       pkt_is_ack,
	input  wire       pkt_type_expected_ack,
	input  wire       packet_end_marker_early,
	input  wire       crc_zero_seed,
	input  wire       crc_bad,
	input  wire       code_len_64,
	input  wire [1:0] data_mode,
	input  wire       packet_dropped
);

	// Byte store; sixteen entries as the buffer holds
	reg  [7:0] buf_mem [0:15];
	reg  [3:0] wr_ptr;
	reg  [3:0] rd_ptr;
	reg  [4:0] level;
	reg  [7:0] ctrl;
	reg  [7:0] flags;
	reg  [7:0] pkt_status;
	reg  [7:0] byte_count;
	reg  [7:0] rx_length;
	reg        clear_pending;
	reg        pkt_bad;
	reg  [7:0] next_rdata;
	wire       rd_buf;
	wire       rd_flags;
	wire       buf_empty;
	wire       buf_full;
	wire       do_push;
	wire       do_pop;
	wire       frame_err;
	wire       good_done;
	wire       complete_event;
	wire       error_event;

	// Address match used by several read and write decodes
	function hit;
		input [7:0] addr;
		input [7:0] target;
		begin
			hit = (addr == target);
		end
	endfunction

	assign rd_buf    = reg_rd && hit(reg_addr, `RRSF_ADDR_BUFFER);
	assign rd_flags  = reg_rd && hit(reg_addr, `RRSF_ADDR_FLAGS);
	assign buf_empty = (level == 5'h00);
	assign buf_full  = (level == `RRSF_DEPTH);
	assign do_push   = rx_byte_valid && !buf_full;
	assign do_pop    = rd_buf && !buf_empty;
	// Error sources of a finished packet
	assign frame_err = crc_bad || packet_end_marker_early ||
		(pkt_is_ack != pkt_type_expected_ack);
	// In transaction mode completion waits for the ACK to leave
	assign complete_event = ack_enable ? ack_sent : packet_done;
	assign good_done      = complete_event && !frame_err;
	assign error_event    = (packet_done && frame_err) || packet_dropped ||
		(length_valid && length_bad && data_mode != `RRSF_MODE_GFSK);

	// Buffer storage
	always @(posedge clk) begin
		if (do_push) begin
			buf_mem[wr_ptr] <= rx_byte;
		end
	end

	// Buffer pointers and fill level
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= 4'h0;
			rd_ptr <= 4'h0;
			level  <= 5'h00;
		end else begin
			if (packet_start_pattern && rx_go && buf_empty) begin
				wr_ptr <= 4'h0;
				rd_ptr <= 4'h0;
			end else begin
				if (do_push) begin
					wr_ptr <= wr_ptr + `RRSF_PTR_ONE;
				end
				if (do_pop) begin
					rd_ptr <= rd_ptr + `RRSF_PTR_ONE;
				end
			end
			if (do_push && !do_pop) begin
				level <= level + `RRSF_ONE5;
			end else if (do_pop && !do_push) begin
				level <= level - `RRSF_ONE5;
			end
		end
	end

	// Control register; start bit self-clears on completion or error
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl  <= `RRSF_CTRL_RESET;
			rx_go <= 1'b0;
		end else begin
			if (reg_wr && hit(reg_addr, `RRSF_ADDR_CTRL)) begin
				ctrl <= reg_wdata;
			end
			if (reg_wr && hit(reg_addr, `RRSF_ADDR_CTRL) &&
				reg_wdata[`RRSF_BIT_START]) begin
				rx_go <= 1'b1;
			end else if (complete_event || error_event) begin
				rx_go <= 1'b0;
			end
		end
	end

	// Event flags; a set in the cycle of a clear always wins
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flags         <= `RRSF_FLAGS_RESET;
			clear_pending <= 1'b0;
		end else begin
			clear_pending <= rd_flags;
			flags[7]      <= 1'b0;
			flags[6]      <= 1'b0;
			flags[`RRSF_BIT_FULL] <= (level == `RRSF_DEPTH) ||
				(do_push && !do_pop && level == `RRSF_DEPTH_LAST);
			// Level flags are registered; half and not-empty follow the fill level one cycle late
			flags[`RRSF_BIT_HALF] <= (level >= `RRSF_HALF_LEVEL);
			flags[`RRSF_BIT_NOT_EMPTY] <= !buf_empty;
			if ((rd_buf && buf_empty) || (rx_byte_valid && buf_full)) begin
				flags[`RRSF_BIT_BUF_ERR] <= 1'b1;
			end else if (rx_go && packet_start_pattern) begin
				flags[`RRSF_BIT_BUF_ERR] <= 1'b0;
			end
			if (good_done) begin
				flags[`RRSF_BIT_COMPLETE] <= 1'b1;
			end else if (clear_pending) begin
				flags[`RRSF_BIT_COMPLETE] <= 1'b0;
			end
			if (error_event) begin
				flags[`RRSF_BIT_ERROR] <= 1'b1;
			end else if (clear_pending) begin
				flags[`RRSF_BIT_ERROR] <= 1'b0;
			end
		end
	end

	// Packet status; mode and code length only from good packets
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pkt_status <= `RRSF_STATUS_RESET;
			pkt_bad    <= 1'b0;
		end else begin
			if (packet_start_pattern) begin
				pkt_status[5] <= 1'b0;
				pkt_bad       <= 1'b0;
			end
			if (length_valid && length_bad) begin
				pkt_status[5] <= 1'b1;
				pkt_bad       <= 1'b1;
			end
			if (packet_done) begin
				pkt_status[7] <= pkt_is_ack;
				pkt_status[6] <= (pkt_is_ack != pkt_type_expected_ack);
				if (packet_end_marker_early) begin
					pkt_status[5] <= 1'b1;
				end
				pkt_status[4] <= crc_zero_seed;
				pkt_status[3] <= crc_bad;
				if (!frame_err && !pkt_bad) begin
					pkt_status[2]   <= code_len_64;
					pkt_status[1:0] <= data_mode;
				end
			end
		end
	end

	// Length register and byte counter
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_length  <= `RRSF_ZERO8;
			byte_count <= `RRSF_ZERO8;
		end else begin
			if (length_valid) begin
				// Bad fields read zero except at the plain GFSK rate
				if (length_bad && data_mode != `RRSF_MODE_GFSK) begin
					rx_length <= `RRSF_ZERO8;
				end else begin
					rx_length <= length_value;
				end
				byte_count <= `RRSF_ZERO8;
			end else if (rx_byte_valid) begin
				byte_count <= byte_count + `RRSF_ONE8;
			end
		end
	end

	// Read data mux; flag clear lands one cycle after this capture
	always @* begin
		next_rdata = `RRSF_ZERO8;
		case (reg_addr)
			`RRSF_ADDR_BUFFER:     next_rdata = buf_mem[rd_ptr];
			`RRSF_ADDR_CTRL:       next_rdata = {rx_go, ctrl[6:0]};
			`RRSF_ADDR_FLAGS:      next_rdata = flags;
			`RRSF_ADDR_PKT_STATUS: next_rdata = pkt_status;
			`RRSF_ADDR_COUNT:      next_rdata = byte_count;
			`RRSF_ADDR_LENGTH:     next_rdata = rx_length;
			default:               next_rdata = `RRSF_ZERO8;
		endcase
	end

	// Registered read data and interrupt output
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= `RRSF_ZERO8;
			irq       <= 1'b0;
		end else begin
			if (reg_rd) begin
				reg_rdata <= buf_empty && rd_buf ? `RRSF_ZERO8 : next_rdata;
			end
			irq <= |(flags[5:0] & ctrl[5:0]);
		end
	end

endmodule

// >>> testbench/rrsf_top_properties.sv
// Concurrent checks on the receive status flag ports
`timescale 1ns/10ps
module rrsf_props (
	input wire       clk, rst_n, reg_rd, reg_wr,
	input wire [7:0] reg_addr, reg_wdata, reg_rdata,
	input wire       irq, rx_go, length_valid, length_bad,
	input wire [7:0] length_value,
	input wire [1:0] data_mode,
	input wire       packet_done, ack_sent, rx_byte_valid, packet_dropped
);
	wire quiet = !(packet_done || ack_sent || packet_dropped || length_valid);
	reg  en_err;
	// Last written error enable, so the irq check knows when it may fire
	always @(posedge clk or negedge rst_n)
		if (!rst_n)
			en_err <= 1'b1;
		else if (reg_wr && reg_addr == 8'h05)
			en_err <= reg_wdata[0];
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_frd;
		reg_rd && reg_addr == 8'h07 && quiet;
	endsequence
	sequence s_len(b);
		length_valid && length_bad == b && (!b || data_mode != 2'h0)
		##2 reg_rd && reg_addr == 8'h0A;
	endsequence
	AST_GO_SET:
		assert property (reg_wr && reg_addr == 8'h05 && reg_wdata[7] |=> rx_go)
		else $error("start bit not set");
	AST_GO_CLR:
		assert property (rx_go && packet_dropped |-> ##[1:2] !rx_go)
		else $error("start bit kept");
	AST_ERR_IRQ:
		assert property (packet_dropped && en_err |-> ##[1:3] irq)
		else $error("no irq on drop");
	AST_ERR_KEEP:
		assert property (packet_dropped ##1 !reg_rd ##1 s_frd |=> reg_rdata[0])
		else $error("error flag lost");
	AST_FLG_CLR:
		assert property (s_frd ##1 quiet [*2] ##1 s_frd |=> !reg_rdata[1:0])
		else $error("flags not cleared");
	AST_CNT_CLR:
		assert property (length_valid ##1 !rx_byte_valid [*4] ##1
			reg_rd && reg_addr == 8'h09 |=> reg_rdata == 8'h00)
		else $error("count not cleared");
	AST_LEN_LD:
		assert property (s_len(1'b0) |=> reg_rdata == $past(length_value, 3))
		else $error("length not loaded");
	AST_LEN_BAD:
		assert property (s_len(1'b1) |=> reg_rdata == 8'h00)
		else $error("bad length kept");
endmodule
bind rrsf_top rrsf_props chk_u (.clk(clk), .rst_n(rst_n), .reg_rd(reg_rd),
	.reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .irq(irq), .rx_go(rx_go),
	.length_valid(length_valid), .length_bad(length_bad),
	.length_value(length_value), .data_mode(data_mode),
	.packet_done(packet_done), .ack_sent(ack_sent),
	.rx_byte_valid(rx_byte_valid), .packet_dropped(packet_dropped));

// >>> testbench/rrsf_host.sv
// Host firmware model on the register port
`timescale 1ns/10ps
module rrsf_host (
	input  wire       clk,
	output reg        reg_rd,
	output reg        reg_wr,
	output reg  [7:0] reg_addr,
	output reg  [7:0] reg_wdata,
	input  wire [7:0] reg_rdata
);
	initial {reg_rd, reg_wr, reg_addr, reg_wdata} = 18'h00000;
	// Read: strobe for one edge, data taken a cycle later; idle address flips
	task rd(input [7:0] a, output [7:0] d);
		@(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
		@(posedge clk) {reg_rd, reg_addr} <= {1'b0, ~a};
		@(posedge clk) d = reg_rdata;
	endtask
	task wr(input [7:0] a, input [7:0] d);
		@(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b0, ~a, ~d};
	endtask
endmodule

// >>> testbench/radio_receive_status_flags_tb_top.sv
// Self-checking bench of the receive status flags block
`timescale 1ns/10ps
module radio_receive_status_flags_tb_top;
	reg         clk = 1'b0, rst_n = 1'b0, ack_en = 1'b0, bad = 1'b0, e;
	reg  [5:0]  pls = 6'h00, pkt = 6'h00;
	reg  [7:0]  rx_byte = 8'h00, len = 8'h00, v, mst, mf, q[$];
	reg  [1:0]  mode = 2'h0;
	reg  [31:0] r = 32'hA0CA3723;
	integer     err_total = 0, samples_checked = 0, i;
	wire        rd, wr, irq, go;
	wire [7:0]  addr, wdata, rdata;
	rrsf_host h_u (.clk(clk), .reg_rd(rd), .reg_wr(wr), .reg_addr(addr),
		.reg_wdata(wdata), .reg_rdata(rdata));
	rrsf_top dut_u (.clk(clk), .rst_n(rst_n), .reg_rd(rd), .reg_wr(wr),
		.reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .irq(irq),
		.rx_go(go), .ack_enable(ack_en), .packet_start_pattern(pls[0]),
		.rx_byte_valid(pls[1]), .rx_byte(rx_byte), .length_valid(pls[2]),
		.length_value(len), .length_bad(bad), .packet_done(pls[3]),
		.ack_sent(pls[4]), .pkt_is_ack(pkt[5]),
		.pkt_type_expected_ack(pkt[4]), .packet_end_marker_early(pkt[3]),
		.crc_zero_seed(pkt[2]), .crc_bad(pkt[1]), .code_len_64(pkt[0]),
		.data_mode(mode), .packet_dropped(pls[5]));
	// 100 MHz clock
	always #5 clk = ~clk;
	function [31:0] nx(input [31:0] s);
		nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task chk(input [7:0] id, input [7:0] x, input [7:0] g);
		samples_checked = samples_checked + 1;
		if (g !== x) begin
			err_total = err_total + 1;
			$display("BAD item %h exp %h got %h", id, x, g);
		end
	endtask
	task rc(input [7:0] a, input [7:0] x);
		h_u.rd(a, v);
		chk(a, x, v);
	endtask
	// Event pulses: 0 start, 1 byte, 2 length, 3 done, 4 ack, 5 drop
	task fire(input integer k);
		@(posedge clk) pls <= 6'h01 << k;
		@(posedge clk) pls <= 6'h00;
	endtask
	// A full buffer drops the byte and flags an error
	task push;
		r = nx(r);
		@(posedge clk) {pls, rx_byte} <= {6'h02, r[7:0]};
		@(posedge clk) {pls, rx_byte} <= {6'h00, ~r[7:0]};
		if (q.size() < 16)
			q.push_back(r[7:0]);
		else
			mf[2] = 1'b1;
	endtask
	task unload8;
		repeat (8) begin
			h_u.rd(8'h00, v);
			chk(8'h00, q.pop_front(), v);
		end
	endtask
	// Flags read; the model forgets complete and error afterwards
	task rf;
		rc(8'h07, {2'h0, q.size() == 16, q.size() > 7, q.size() > 0, mf[2:0]});
		mf[1:0] = 2'h0;
	endtask
	task end_sim;
		if (err_total == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		{mst, mf} = {8'h08, 8'h00};
		rc(8'h05, 8'h07);
		rf;
		rc(8'h08, mst);
		rc(8'h0A, 8'h00);
		rc(8'h09, 8'h00);
		rc(8'h3F, 8'h00);
		// Corrupt length outside GFSK, then a good one
		r = nx(r);
		@(posedge clk) {len, bad, mode} <= {r[7:0], 3'h5};
		fire(2);
		{mst[5], mf[0]} = 2'h3;
		rc(8'h0A, 8'h00);
		rc(8'h09, 8'h00);
		@(posedge clk) {len, bad} <= {8'h08 | r[10:8], 1'b0};
		fire(2);
		rc(8'h0A, len);
		rc(8'h09, 8'h00);
		repeat (len) push;
		rc(8'h09, len);
		repeat (17 - len) push;
		rf;
		unload8;
		rf;
		unload8;
		rf;
		h_u.wr(8'h05, 8'h87);
		fire(0);
		mf[2] = 1'b0;
		rf;
		rc(8'h00, 8'h00);
		mf[2] = 1'b1;
		rf;
		// Packets 3, 6 and 7 carry errors; odd ones use transaction mode
		for (i = 0; i < 8; i = i + 1) begin
			r = nx(r);
			e = i == 3 || i > 5;
			fire(0);
			mf[2] = 1'b0;
			@(posedge clk) begin
				{ack_en, mode} <= {i[0], i[1:0]};
				pkt <= {r[0], r[0] ^ (i == 6), i == 3, r[1], i == 7, r[2]};
			end
			fire(3);
			mst = {pkt[5], i == 6, pkt[3:1], e ? mst[2:0] : {r[2], i[1:0]}};
			mf[0] = e;
			if (i[0] && !e) begin
				rf;
				fire(4);
			end
			mf[1] = !e;
			repeat (3) @(posedge clk);
			chk(8'hEE, {7'h00, |mf}, {7'h00, irq});
			rc(8'h08, mst);
			rf;
			if (!e)
				rf;
			h_u.wr(8'h05, 8'h87);
		end
		fire(5);
		mf[0] = 1'b1;
		rf;
		end_sim;
	end
	// Hang guard, far beyond the expected run
	initial begin
		#300000;
		err_total = err_total + 1;
		end_sim;
	end
endmodule
